// ### hdl/sdh_pkg.sv
package sdh_pkg;

  // register port geometry
  localparam int REG_AW = 12;
  localparam int REG_DW = 8;

  // register offsets on the plain register port
  localparam logic [REG_AW-1:0] REG_MODULE_DISABLE0 = 12'hEE1;
  localparam logic [REG_AW-1:0] REG_SCANNER_CONTROL = 12'h010;
  localparam logic [REG_AW-1:0] REG_SCAN_LOW_ADDR   = 12'h011;
  localparam logic [REG_AW-1:0] REG_SCAN_HIGH_ADDR  = 12'h012;
  localparam logic [REG_AW-1:0] REG_SCAN_LOW_END    = 12'h013;
  localparam logic [REG_AW-1:0] REG_SCAN_HIGH_END   = 12'h014;
  localparam logic [REG_AW-1:0] REG_SCAN_LOW_DATA   = 12'h015;
  localparam logic [REG_AW-1:0] REG_SCAN_HIGH_DATA  = 12'h016;

  // module_disable_reg0 fields
  localparam int MD_CHECKER_OFF_BIT = 4;
  localparam int MD_SCANNER_OFF_BIT = 3;
  localparam logic [REG_DW-1:0] MD_RESET = 8'h00;

  // scanner_control fields
  localparam int CTRL_EN_BIT     = 7;
  localparam int CTRL_GO_BIT     = 6;
  localparam int CTRL_BUSY_BIT   = 5;
  localparam int CTRL_FROZEN_BIT = 4;
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_MODE_W     = 2;
  localparam logic [REG_DW-1:0] CTRL_RESET = 8'h00;

  // width of a byte lane in the split address and data registers
  localparam int BYTE_W = 8;

  // scanner operating modes
  typedef enum logic [CTRL_MODE_W-1:0] {
    SDH_MODE_CONCURRENT = 2'h0,
    SDH_MODE_TRIGGERED  = 2'h1,
    SDH_MODE_PEEK       = 2'h2,
    SDH_MODE_BURST      = 2'h3
  } sdh_mode_t;

  // scan sequencer states, gray along idle-run-read-run
  typedef enum logic [1:0] {
    SDH_ST_IDLE   = 2'h0,
    SDH_ST_RUN    = 2'h1,
    SDH_ST_READ   = 2'h3,
    SDH_ST_FROZEN = 2'h2
  } sdh_state_t;

endpackage

// ### hdl/sdh_flash_rd.sv
`timescale 1ns/1ps
module sdh_flash_rd
  import sdh_pkg::*;
#(
  parameter int FLASH_AW = 16,
  parameter int FLASH_DW = 16
) (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                resetn,
  // request from the sequencer
  input  wire logic                start,
  input  wire logic [FLASH_AW-1:0] addr,
  output logic                     busy,
  output logic                     done,
  output logic [FLASH_DW-1:0]      data,
  // program_flash read port
  output logic                     flash_rd_req,
  output logic [FLASH_AW-1:0]      flash_addr,
  input  wire logic                flash_rd_ack,
  input  wire logic [FLASH_DW-1:0] flash_rd_data
);

  // request held until the flash acknowledges it
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      flash_rd_req <= 1'b0;
    end else if (start) begin
      flash_rd_req <= 1'b1;
    end else if (flash_rd_ack) begin
      flash_rd_req <= 1'b0;
    end
  end

  // address is latched so the caller may move on
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      flash_addr <= '0;
    end else if (start) begin
      flash_addr <= addr;
    end
  end

  // completion pulse and captured word
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      done <= 1'b0;
      data <= '0;
    end else begin
      done <= flash_rd_req & flash_rd_ack;
      if (flash_rd_req && flash_rd_ack) begin
        data <= flash_rd_data;
      end
    end
  end

  assign busy = flash_rd_req;

endmodule

// ### hdl/sdh_halt_ctrl.sv
`timescale 1ns/1ps
module sdh_halt_ctrl
  import sdh_pkg::*;
#(
  parameter int FLASH_AW = 16,
  parameter int FLASH_DW = 16
) (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                resetn,
  // register port
  input  wire logic [REG_AW-1:0]   reg_addr,
  input  wire logic [REG_DW-1:0]   reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [REG_DW-1:0]        reg_rdata,
  // configuration fuse
  input  wire logic                scanner_fuse_allow,
  // debug_unit handshake
  input  wire logic                ext_halt,
  input  wire logic                pc_data_break,
  input  wire logic                software_breakpoint,
  input  wire logic                step_mode,
  input  wire logic                dbg_mode,
  output logic                     dbg_entry_ok,
  // core side
  input  wire logic                core_exec,
  output logic                     core_hold,
  // trigger source for triggered mode
  input  wire logic                scan_trigger,
  // program_flash read port
  output logic                     flash_rd_req,
  output logic [FLASH_AW-1:0]      flash_addr,
  input  wire logic                flash_rd_ack,
  input  wire logic [FLASH_DW-1:0] flash_rd_data,
  // checker feed and module state
  output logic                     chk_valid,
  output logic [FLASH_DW-1:0]      chk_data,
  output logic                     checker_module_off,
  output logic                     scanner_module_off
);

  // split byte registers cannot hold more than two lanes
  generate
    if (FLASH_AW <= BYTE_W || FLASH_AW > 2 * BYTE_W) begin : g_bad_aw
      $error("FLASH_AW must lie in 9..16");
    end
    if (FLASH_DW <= BYTE_W || FLASH_DW > 2 * BYTE_W) begin : g_bad_dw
      $error("FLASH_DW must lie in 9..16");
    end
  endgenerate

  localparam int AHI_W = FLASH_AW - BYTE_W;
  localparam int DHI_W = FLASH_DW - BYTE_W;

  // decode shared by the write and read paths
  function automatic logic reg_hit(input logic [REG_AW-1:0] a,
                                   input logic [REG_AW-1:0] off);
    reg_hit = (a == off);
  endfunction

  // registers
  logic [REG_DW-1:0]   md_reg;
  logic                en_reg;
  logic                go_reg;
  sdh_mode_t           mode_reg;
  logic [FLASH_AW-1:0] scan_addr_reg;
  logic [FLASH_AW-1:0] scan_end_reg;
  logic                pend_reg;
  sdh_state_t          state_reg;
  sdh_state_t          state_next;
  logic [REG_DW-1:0]   rdata_next;
  logic                chk_valid_reg;
  logic [FLASH_DW-1:0] chk_data_reg;

  // sequencer helpers
  logic                scan_avail;
  logic                run_ok;
  logic                ctrl_wr;
  logic                go_set;
  logic                go_clr;
  logic                want;
  logic                start;
  logic                last;
  logic                fl_busy;
  logic                fl_done;
  logic [FLASH_DW-1:0] fl_data;
  logic                step_block;

  // fuse gates the disable bit; with the fuse clear the scanner is gone
  assign scan_avail = scanner_fuse_allow
                    & ~md_reg[MD_SCANNER_OFF_BIT];
  assign run_ok     = scan_avail & en_reg;
  assign ctrl_wr    = reg_wr & reg_hit(reg_addr, REG_SCANNER_CONTROL);
  assign last       = (scan_addr_reg == scan_end_reg);

  // module disable register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      md_reg <= MD_RESET;
    end else if (reg_wr && reg_hit(reg_addr, REG_MODULE_DISABLE0)) begin
      md_reg <= reg_wdata;
    end
  end

  // each module has its own independent disable bit
  assign checker_module_off = md_reg[MD_CHECKER_OFF_BIT];
  assign scanner_module_off = ~scan_avail;

  // enable and mode bits
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      en_reg   <= CTRL_RESET[CTRL_EN_BIT];
      mode_reg <= sdh_mode_t'(CTRL_RESET[CTRL_MODE_LSB +: CTRL_MODE_W]);
    end else if (ctrl_wr) begin
      en_reg   <= reg_wdata[CTRL_EN_BIT];
      mode_reg <= sdh_mode_t'(reg_wdata[CTRL_MODE_LSB +: CTRL_MODE_W]);
    end
  end

  // a trigger write only counts while the scanner is usable; the write
  // may come from the core or from the debug instruction after exit
  assign go_set = ctrl_wr & reg_wdata[CTRL_GO_BIT] & reg_wdata[CTRL_EN_BIT]
                & scan_avail;
  assign go_clr = (state_reg == SDH_ST_READ && fl_done && last)
                | ~run_ok
                | (ctrl_wr & ~reg_wdata[CTRL_GO_BIT]);

  // go bit: set wins over a clear landing in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      go_reg <= CTRL_RESET[CTRL_GO_BIT];
    end else if (go_set) begin
      go_reg <= 1'b1;
    end else if (go_clr) begin
      go_reg <= 1'b0;
    end
  end

  // scan address and end address, software write beats the increment
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      scan_addr_reg <= '0;
    end else if (reg_wr && reg_hit(reg_addr, REG_SCAN_LOW_ADDR)) begin
      scan_addr_reg[BYTE_W-1:0] <= reg_wdata;
    end else if (reg_wr && reg_hit(reg_addr, REG_SCAN_HIGH_ADDR)) begin
      scan_addr_reg[FLASH_AW-1:BYTE_W] <= reg_wdata[AHI_W-1:0];
    end else if (state_reg == SDH_ST_READ && fl_done && !last) begin
      // the address only moves on a finished read, so a suspended burst
      // picks up at the next word after debug exit
      scan_addr_reg <= scan_addr_reg + FLASH_AW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      scan_end_reg <= '0;
    end else if (reg_wr && reg_hit(reg_addr, REG_SCAN_LOW_END)) begin
      scan_end_reg[BYTE_W-1:0] <= reg_wdata;
    end else if (reg_wr && reg_hit(reg_addr, REG_SCAN_HIGH_END)) begin
      scan_end_reg[FLASH_AW-1:BYTE_W] <= reg_wdata[AHI_W-1:0];
    end
  end

  // pending scan cycle for triggered and peek modes; nothing is latched
  // while in debug mode or unusable, and a new request beats the consume
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pend_reg <= 1'b0;
    end else if (!run_ok || !go_reg) begin
      pend_reg <= 1'b0;
    end else if (!dbg_mode && mode_reg == SDH_MODE_TRIGGERED
                 && scan_trigger) begin
      pend_reg <= 1'b1;
    end else if (!dbg_mode && mode_reg == SDH_MODE_PEEK
                 && core_exec && !pc_data_break) begin
      // a breakpointed instruction is not executed, so it is not peeked
      pend_reg <= 1'b1;
    end else if (start) begin
      pend_reg <= 1'b0;
    end
  end

  // concurrent and burst always have a scan cycle ready
  always_comb begin
    unique case (mode_reg)
      SDH_MODE_CONCURRENT: want = 1'b1;
      SDH_MODE_BURST:      want = 1'b1;
      SDH_MODE_TRIGGERED:  want = pend_reg;
      SDH_MODE_PEEK:       want = pend_reg;
    endcase
  end

  // no new access when a halt is asking or the core is in debug; a halt
  // one cycle ahead of the scan pushes both past exit
  assign start = (state_reg == SDH_ST_RUN) & want & run_ok & go_reg
               & ~ext_halt
               & ~dbg_mode
               & ~fl_busy;

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SDH_ST_IDLE: begin
        // a trigger written beside a halt still moves to RUN and waits there, or in FROZEN under debug
        if (go_reg && run_ok) begin
          state_next = SDH_ST_RUN;
        end
      end
      SDH_ST_RUN: begin
        if (!run_ok || !go_reg) begin
          state_next = SDH_ST_IDLE;
        end else if (dbg_mode) begin
          state_next = SDH_ST_FROZEN;
        end else if (start) begin
          state_next = SDH_ST_READ;
        end
      end
      SDH_ST_READ: begin
        // an access in flight is always finished before yielding
        if (fl_done) begin
          if (last || !run_ok) begin
            state_next = SDH_ST_IDLE;
          end else if (dbg_mode || ext_halt) begin
            state_next = SDH_ST_FROZEN;
          end else begin
            state_next = SDH_ST_RUN;
          end
        end
      end
      SDH_ST_FROZEN: begin
        if (!run_ok || !go_reg) begin
          state_next = SDH_ST_IDLE;
        end else if (!dbg_mode && !ext_halt) begin
          state_next = SDH_ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_reg <= SDH_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // in single step a scan that is ready must reach flash first
  assign step_block = step_mode & (state_reg == SDH_ST_RUN) & want
                    & run_ok & go_reg;

  // entry waits for any scan cycle in flight, whether the halt came from
  // outside or from a software breakpoint stalled behind it; the stalled
  // instruction itself may or may not have completed by then
  assign dbg_entry_ok = (state_reg != SDH_ST_READ)
                      & ~step_block;

  // the core stalls for a stolen cycle, and for a burst except between reads under halt or debug
  always_comb begin
    core_hold = 1'b0;
    if (state_reg == SDH_ST_READ && mode_reg != SDH_MODE_PEEK) begin
      core_hold = 1'b1;
    end else if (mode_reg == SDH_MODE_BURST && state_reg == SDH_ST_RUN) begin
      core_hold = ~ext_halt & ~dbg_mode;
    end
  end

  // program_flash access engine
  sdh_flash_rd #(
    .FLASH_AW (FLASH_AW),
    .FLASH_DW (FLASH_DW)
  ) u_flash_rd (
    .sys_clk       (sys_clk),
    .resetn        (resetn),
    .start         (start),
    .addr          (scan_addr_reg),
    .busy          (fl_busy),
    .done          (fl_done),
    .data          (fl_data),
    .flash_rd_req  (flash_rd_req),
    .flash_addr    (flash_addr),
    .flash_rd_ack  (flash_rd_ack),
    .flash_rd_data (flash_rd_data)
  );

  // checker feed, silent while the checker is switched off
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      chk_valid_reg <= 1'b0;
      chk_data_reg  <= '0;
    end else begin
      chk_valid_reg <= fl_done & ~md_reg[MD_CHECKER_OFF_BIT];
      if (fl_done) begin
        chk_data_reg <= fl_data;
      end
    end
  end

  assign chk_valid = chk_valid_reg;
  assign chk_data  = chk_data_reg;

  // read mux; nothing here depends on debug state so a halted core can
  // still inspect the scan
  always_comb begin
    rdata_next = '0;
    if (reg_hit(reg_addr, REG_MODULE_DISABLE0)) begin
      rdata_next = md_reg;
    end else if (reg_hit(reg_addr, REG_SCANNER_CONTROL)) begin
      rdata_next[CTRL_EN_BIT]     = en_reg;
      rdata_next[CTRL_GO_BIT]     = go_reg;
      rdata_next[CTRL_BUSY_BIT]   = (state_reg != SDH_ST_IDLE);
      rdata_next[CTRL_FROZEN_BIT] = (state_reg == SDH_ST_FROZEN);
      rdata_next[CTRL_MODE_LSB +: CTRL_MODE_W] = mode_reg;
    end else if (reg_hit(reg_addr, REG_SCAN_LOW_ADDR)) begin
      rdata_next = scan_addr_reg[BYTE_W-1:0];
    end else if (reg_hit(reg_addr, REG_SCAN_HIGH_ADDR)) begin
      rdata_next[AHI_W-1:0] = scan_addr_reg[FLASH_AW-1:BYTE_W];
    end else if (reg_hit(reg_addr, REG_SCAN_LOW_END)) begin
      rdata_next = scan_end_reg[BYTE_W-1:0];
    end else if (reg_hit(reg_addr, REG_SCAN_HIGH_END)) begin
      rdata_next[AHI_W-1:0] = scan_end_reg[FLASH_AW-1:BYTE_W];
    end else if (reg_hit(reg_addr, REG_SCAN_LOW_DATA)) begin
      rdata_next = chk_data_reg[BYTE_W-1:0];
    end else if (reg_hit(reg_addr, REG_SCAN_HIGH_DATA)) begin
      rdata_next[DHI_W-1:0] = chk_data_reg[FLASH_DW-1:BYTE_W];
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

// ### sim/sdh_flash_model.sv
`timescale 1ns/1ps
module sdh_flash_model #(
  parameter int FLASH_AW = 16,
  parameter int FLASH_DW = 16
) (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                resetn,
  // answer speed, high adds three wait cycles
  input  wire logic                slow,
  // program_flash read port
  input  wire logic                flash_rd_req,
  input  wire logic [FLASH_AW-1:0] flash_addr,
  output logic                     flash_rd_ack,
  output logic [FLASH_DW-1:0]      flash_rd_data
);
  logic [1:0] wait_reg;
  logic       give;

  // answer only once per request, never in the cycle after an ack
  assign give = flash_rd_req && !flash_rd_ack && (!slow || wait_reg == 2'h3);

  // data toggles off the ack cycle so a stray sample shows up
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wait_reg <= 2'h0;
      flash_rd_ack <= 1'b0;
      flash_rd_data <= '1;
    end else begin
      flash_rd_ack <= give;
      flash_rd_data <= give ? FLASH_DW'(flash_addr ^ 16'h5A3C)
                            : ~flash_rd_data;
      wait_reg <= (flash_rd_req && !give) ? wait_reg + 2'h1 : 2'h0;
    end
  end
endmodule

// ### sim/sdh_halt_ctrl_monitor.sv
`timescale 1ns/1ps
module sdh_halt_ctrl_monitor
  import sdh_pkg::*;
#(
  parameter int FLASH_AW = 16,
  parameter int FLASH_DW = 16
) (
  // clock and reset
  input wire logic                sys_clk,
  input wire logic                resetn,
  // watched ports
  input wire logic                reg_rd,
  input wire logic [REG_DW-1:0]   reg_rdata,
  input wire logic                scanner_fuse_allow,
  input wire logic                ext_halt,
  input wire logic                dbg_mode,
  input wire logic                dbg_entry_ok,
  input wire logic                flash_rd_req,
  input wire logic [FLASH_AW-1:0] flash_addr,
  input wire logic                flash_rd_ack,
  input wire logic [FLASH_DW-1:0] flash_rd_data,
  input wire logic                chk_valid,
  input wire logic [FLASH_DW-1:0] chk_data,
  input wire logic                checker_module_off,
  input wire logic                scanner_module_off
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // steps of one flash access
  sequence s_wait;
    flash_rd_req && !flash_rd_ack;
  endsequence
  sequence s_ack_on;
    flash_rd_ack && !checker_module_off;
  endsequence

  property p_no_start;
    (ext_halt || dbg_mode) && !flash_rd_req |=> !flash_rd_req;
  endproperty
  a_no_start: assert property (p_no_start)
    else $error("flash read started while halted");
  property p_req_hold;
    s_wait |=> flash_rd_req && $stable(flash_addr);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("flash request dropped or moved before ack");
  property p_entry_block;
    flash_rd_req |-> !dbg_entry_ok;
  endproperty
  a_entry_block: assert property (p_entry_block)
    else $error("debug entry allowed during flash access");
  property p_feed;
    s_ack_on ##1 !checker_module_off |=> chk_valid;
  endproperty
  a_feed: assert property (p_feed)
    else $error("checker word missing two cycles after ack");
  property p_feed_data;
    chk_valid |-> chk_data == $past(flash_rd_data, 2);
  endproperty
  a_feed_data: assert property (p_feed_data)
    else $error("checker word differs from flash data");
  property p_checker_quiet;
    checker_module_off [*3] |-> !chk_valid;
  endproperty
  a_checker_quiet: assert property (p_checker_quiet)
    else $error("checker fed while switched off");
  property p_fuse_off;
    !scanner_fuse_allow |-> scanner_module_off;
  endproperty
  a_fuse_off: assert property (p_fuse_off)
    else $error("scanner available with fuse cleared");
  property p_off_quiet;
    scanner_module_off && !flash_rd_req |=> !flash_rd_req;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("disabled scanner issued a flash read");
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside its cycle");
endmodule

bind sdh_halt_ctrl sdh_halt_ctrl_monitor #(
  .FLASH_AW(FLASH_AW),
  .FLASH_DW(FLASH_DW)
) sdh_halt_ctrl_monitor_i (
  .sys_clk, .resetn, .reg_rd, .reg_rdata, .scanner_fuse_allow, .ext_halt,
  .dbg_mode, .dbg_entry_ok, .flash_rd_req, .flash_addr, .flash_rd_ack,
  .flash_rd_data, .chk_valid, .chk_data, .checker_module_off,
  .scanner_module_off
);

// ### sim/scanner_debug_halt_control_tb.sv
`timescale 1ns/1ps
module scanner_debug_halt_control_tb;
  import sdh_pkg::*;
  typedef struct packed {
    sdh_mode_t m; logic [7:0] a; logic [7:0] e; logic s; logic [7:0] n;
  } sdh_row_t;
  // stimulus
  logic              sys_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0;
  logic              reg_rd = 1'b0, scanner_fuse_allow = 1'b1, feed = 1'b0;
  logic              ext_halt = 1'b0, pc_data_break = 1'b0, slow = 1'b0;
  logic              software_breakpoint = 1'b0, step_mode = 1'b0;
  logic              dbg_mode = 1'b0, core_exec = 1'b0, scan_trigger = 1'b0;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [REG_DW-1:0] reg_wdata = '0, d;
  // responses
  logic [REG_DW-1:0] reg_rdata;
  logic              dbg_entry_ok, core_hold, flash_rd_req, flash_rd_ack;
  logic              chk_valid, checker_module_off, scanner_module_off;
  logic [15:0]       flash_addr, flash_rd_data, chk_data;
  logic [15:0]       words[$];
  int                failures = 0, total_checks = 0, n_ack = 0, k, j;
  sdh_row_t          rows [4] = '{
    '{SDH_MODE_CONCURRENT, 8'h02, 8'h05, 1'b0, 8'h04},
    '{SDH_MODE_TRIGGERED, 8'h08, 8'h0A, 1'b1, 8'h03},
    '{SDH_MODE_PEEK, 8'h0C, 8'h0D, 1'b0, 8'h02},
    '{SDH_MODE_BURST, 8'h10, 8'h17, 1'b1, 8'h08}};

  sdh_halt_ctrl sdh_halt_ctrl_i (.sys_clk, .resetn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .scanner_fuse_allow, .ext_halt,
    .pc_data_break, .software_breakpoint, .step_mode, .dbg_mode,
    .dbg_entry_ok, .core_exec, .core_hold, .scan_trigger, .flash_rd_req,
    .flash_addr, .flash_rd_ack, .flash_rd_data, .chk_valid, .chk_data,
    .checker_module_off, .scanner_module_off);
  sdh_flash_model sdh_flash_model_i (.sys_clk, .resetn, .slow,
    .flash_rd_req, .flash_addr, .flash_rd_ack, .flash_rd_data);

  // clock, trigger pulses and collection of what the checker receives
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    scan_trigger <= feed & ~scan_trigger;
    core_exec <= feed & ~core_exec;
    if (chk_valid === 1'b1) words.push_back(chk_data);
    if (flash_rd_ack === 1'b1) n_ack++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [REG_AW-1:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [REG_AW-1:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic scan(input sdh_mode_t m, input logic [7:0] a, e);
    wr(REG_SCAN_LOW_ADDR, a);
    wr(REG_SCAN_HIGH_ADDR, 8'h00);
    wr(REG_SCAN_LOW_END, e);
    wr(REG_SCAN_HIGH_END, 8'h00);
    feed <= (m == SDH_MODE_TRIGGERED || m == SDH_MODE_PEEK);
    wr(REG_SCANNER_CONTROL, {6'h30, m});
  endtask
  // polls go under a bound; a stuck scan shows as missing words
  task automatic wait_idle;
    d = 8'hFF;
    for (int i = 0; i < 300 && d[CTRL_GO_BIT] !== 1'b0; i++)
      rd(REG_SCANNER_CONTROL);
    feed = 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic expect_words(input logic [7:0] a, input logic [7:0] n);
    check(16'(words.size()), {8'h00, n});
    foreach (words[i]) check(words[i], {8'h00, a + 8'(i)} ^ 16'h5A3C);
    words.delete();
  endtask
  task automatic wait_req;
    for (int i = 0; i < 50 && flash_rd_req !== 1'b1; i++)
      @(posedge sys_clk);
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // watchdog, far beyond the several hundred cycles the tests need
  initial begin
    #100us;
    failures++;
    finish_test();
  end

  // main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    foreach (rows[r]) begin
      slow <= rows[r].s;
      scan(rows[r].m, rows[r].a, rows[r].e);
      wait_idle();
      expect_words(rows[r].a, rows[r].n);
    end
    // halt in the middle of a slow burst; acks counted from its start
    k = n_ack;
    scan(SDH_MODE_BURST, 8'h30, 8'h37);
    wait_req();
    repeat (6) @(posedge sys_clk);
    wait_req();
    check({15'h0, core_hold}, 16'h0001);
    ext_halt <= 1'b1;
    repeat (8) @(posedge sys_clk);
    j = n_ack;
    repeat (20) @(posedge sys_clk);
    check(16'(n_ack), 16'(j));
    check({15'h0, core_hold}, 16'h0000);
    rd(REG_SCANNER_CONTROL);
    check({8'h00, d & 8'h10}, 16'h0010);
    rd(REG_SCAN_LOW_ADDR);
    check({8'h00, d}, 16'(8'h30 + 8'(j - k)));
    ext_halt <= 1'b0;
    wait_idle();
    expect_words(8'h30, 8'h08);
    // go written under halt, then under debug with a breakpoint
    for (int v = 0; v < 2; v++) begin
      ext_halt <= (v == 0);
      dbg_mode <= (v == 1);
      software_breakpoint <= (v == 1);
      k = n_ack;
      scan(SDH_MODE_BURST, 8'h40, 8'h43);
      repeat (10) @(posedge sys_clk);
      check(16'(n_ack), 16'(k));
      check({15'h0, dbg_entry_ok}, 16'h0001);
      check({15'h0, core_hold}, 16'h0000);
      ext_halt <= 1'b0;
      dbg_mode <= 1'b0;
      software_breakpoint <= 1'b0;
      wait_idle();
      expect_words(8'h40, 8'h04);
    end
    // single step and breakpoint with a ready scan
    step_mode <= 1'b1;
    software_breakpoint <= 1'b1;
    scan(SDH_MODE_CONCURRENT, 8'h50, 8'h50);
    @(posedge sys_clk);
    #1 check({15'h0, dbg_entry_ok}, 16'h0000);
    wait_idle();
    expect_words(8'h50, 8'h01);
    step_mode <= 1'b0;
    software_breakpoint <= 1'b0;
    // peek of an instruction stopped by a breakpoint
    pc_data_break <= 1'b1;
    k = n_ack;
    scan(SDH_MODE_PEEK, 8'h58, 8'h58);
    repeat (12) @(posedge sys_clk);
    check(16'(n_ack), 16'(k));
    pc_data_break <= 1'b0;
    wait_idle();
    expect_words(8'h58, 8'h01);
    // module disable bits and the fuse
    wr(REG_MODULE_DISABLE0, 8'h10);
    #1 check({14'h0, checker_module_off, scanner_module_off}, 16'h2);
    k = n_ack;
    scan(SDH_MODE_CONCURRENT, 8'h60, 8'h61);
    wait_idle();
    check(16'(n_ack), 16'(k + 2));
    expect_words(8'h60, 8'h00);
    for (int v = 0; v < 2; v++) begin
      scanner_fuse_allow <= (v == 0);
      wr(REG_MODULE_DISABLE0, v == 0 ? 8'h08 : 8'h00);
      rd(REG_MODULE_DISABLE0);
      check({8'h00, d}, v == 0 ? 16'h0008 : 16'h0000);
      check({15'h0, scanner_module_off}, 16'h0001);
      scan(SDH_MODE_CONCURRENT, 8'h68, 8'h69);
      repeat (10) @(posedge sys_clk);
      rd(REG_SCANNER_CONTROL);
      check({8'h00, d & 8'h60}, 16'h0000);
      check(16'(n_ack), 16'(k + 2));
    end
    scanner_fuse_allow <= 1'b1;
    // reset in the middle of a burst
    scan(SDH_MODE_BURST, 8'h70, 8'h77);
    wait_req();
    resetn <= 1'b0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    #1 check({15'h0, flash_rd_req}, 16'h0000);
    rd(REG_SCANNER_CONTROL);
    check({8'h00, d}, {8'h00, CTRL_RESET});
    rd(REG_MODULE_DISABLE0);
    check({8'h00, d}, {8'h00, MD_RESET});
    rd(12'h7FF);
    check({8'h00, d}, 16'h0000);
    finish_test();
  end
endmodule
